// ==== wdg_pkg.sv ====
// constants, types and register map of the watchdog timer
// assumes a 32-bit avalon-mm slave port with byte addressing
package wdg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_OPTION = 8'h04;   // software_mode_option
  localparam logic [7:0] IDX_CTRL   = 8'h07;   // watchdog_timeout_control
  localparam logic [7:0] IDX_STATUS = 8'h08;   // live watchdog state
  localparam logic [7:0] IDX_CMD    = 8'h09;   // refresh / sleep strobes

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] OPTION_RST = 8'h00;   // hardware mode
  localparam logic [3:0] CTRL_RST   = 4'h1;    // factor 625

  // the one option code that selects software mode
  localparam logic [7:0] SW_CODE    = 8'hAA;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int SEL_MSB     = 3;              // timeout_select top bit
  localparam int STAT_RUN    = 0;              // counting
  localparam int STAT_SWMODE = 1;              // software mode active
  localparam int STAT_FIRE   = 2;              // reset being driven
  localparam int STAT_STOP   = 3;              // halted by sleep
  localparam int CMD_REFRESH = 0;              // refresh strobe
  localparam int CMD_SLEEP   = 1;              // sleep strobe

  ////////////////////////////////////////////////////////////////////////////
  // timing counts in core clock cycles; the factor step counts ticks
  localparam int PRESC_DIV   = 500;            // master clocks per tick
  localparam int FACTOR_STEP = 625;            // factor per selector step
  localparam int RST_LEN     = 4;              // reset pulse length

  // watchdog states
  typedef enum logic [1:0] {
    st_run,
    st_stop,
    st_fire
  } wdg_state_t;

endpackage : wdg_pkg

// ==== wdg_timer.sv ====
// watchdog timer: prescaler, timeout counter, mode option, bus slave
// assumes synchronous inputs, one clock, avalon-mm master with waitrequest
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps

module wdg_timer #(
  parameter int unsigned PRESC_DIV = wdg_pkg::PRESC_DIV  // shorten in sim
) (
  input  wire logic        core_clk_i,       // 40 mhz core clock
  input  wire logic        rst_i,            // async reset, high
  input  wire logic [7:0]  address_i,        // avalon byte address
  input  wire logic        read_i,           // avalon read
  input  wire logic        write_i,          // avalon write
  input  wire logic [3:0]  byteenable_i,     // avalon byte lanes
  input  wire logic [31:0] writedata_i,      // avalon write data
  output logic      [31:0] readdata_o,       // avalon read data
  output logic             waitrequest_o,    // avalon stall
  input  wire logic        refresh_instr_i,  // refresh_instruction pulse
  input  wire logic        sleep_instr_i,    // sleep_instruction pulse
  output logic             core_rst_n_o      // reset to controller_core
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  wdg_pkg::wdg_state_t state_r;              // watchdog state
  logic [7:0]  opt_r;                        // software_mode_code
  logic [3:0]  sel_r;                        // timeout_select
  logic [8:0]  presc_r;                      // prescaler count
  logic [13:0] tick_r;                       // ticks since refresh or timeout
  logic [2:0]  fire_r;                       // reset pulse count
  logic        rst_n_r;                      // reset output flop
  logic        ack_r;                        // bus answer cycle
  logic [31:0] rdata_r;                      // read data flop
  logic        first_r;                      // first cycle after reset
  logic        sw_mode;                      // software mode active
  logic        tick;                         // watchdog_tick pulse
  logic        expire;                       // timeout reached
  logic        refresh_evt;                  // any refresh source
  logic        sleep_evt;                    // any sleep source
  logic        bus_req;                      // read or write pending
  logic        wr_take;                      // write takes effect
  logic        cmd_wr;                       // command register write

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // division factor of a selector value
  function automatic logic [13:0] factor(input logic [3:0] sel);
    logic [13:0] f;
    if (sel == 4'h0) begin
      f = 14'h0001;                          // smallest delay
    end else begin
      f = 14'(wdg_pkg::FACTOR_STEP * int'(sel));
    end
    return f;
  endfunction : factor

  // address match for a register index
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] idx);
    return (adr[1:0] == 2'b00) && (adr[7:2] == idx[5:0]);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one stall cycle, then the answer edge

  assign bus_req       = read_i | write_i;
  assign waitrequest_o = bus_req & ~ack_r;
  assign wr_take       = write_i & ack_r;
  assign readdata_o    = rdata_r;

  // answer flag toggles on each pending request
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  // read data captured in the stall cycle, stands at the answer edge
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (read_i && !ack_r) begin
      rdata_r <= 32'h0000_0000;              // unmapped reads zero
      if (hit(address_i, wdg_pkg::IDX_OPTION)) begin
        rdata_r[7:0] <= opt_r;
      end else if (hit(address_i, wdg_pkg::IDX_CTRL)) begin
        rdata_r[wdg_pkg::SEL_MSB:0] <= sel_r;
      end else if (hit(address_i, wdg_pkg::IDX_STATUS)) begin
        rdata_r[wdg_pkg::STAT_RUN]    <= (state_r == wdg_pkg::st_run);
        rdata_r[wdg_pkg::STAT_SWMODE] <= sw_mode;
        rdata_r[wdg_pkg::STAT_FIRE]   <= (state_r == wdg_pkg::st_fire);
        rdata_r[wdg_pkg::STAT_STOP]   <= (state_r == wdg_pkg::st_stop);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  // option byte; reset keeps hardware mode
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      opt_r <= wdg_pkg::OPTION_RST;
    end else if (wr_take && byteenable_i[0]
                 && hit(address_i, wdg_pkg::IDX_OPTION)) begin
      opt_r <= writedata_i[7:0];
    end
  end

  // timeout selector; upper bits are dropped
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_r <= wdg_pkg::CTRL_RST;
    end else if (wr_take && byteenable_i[0]
                 && hit(address_i, wdg_pkg::IDX_CTRL)) begin
      sel_r <= writedata_i[wdg_pkg::SEL_MSB:0];
    end
  end

  // only the exact code enables software mode
  assign sw_mode = (opt_r == wdg_pkg::SW_CODE);

  // command strobes from the bus join the instruction pulses
  assign cmd_wr      = wr_take && byteenable_i[0]
                       && hit(address_i, wdg_pkg::IDX_CMD);
  assign refresh_evt = refresh_instr_i
                       | (cmd_wr & writedata_i[wdg_pkg::CMD_REFRESH]);
  assign sleep_evt   = sleep_instr_i
                       | (cmd_wr & writedata_i[wdg_pkg::CMD_SLEEP]);

  ////////////////////////////////////////////////////////////////////////////
  // timebase

  // tick at the last prescaler count while running
  assign tick   = (state_r == wdg_pkg::st_run)
                  && (presc_r == 9'(PRESC_DIV - 1));
  // timeout when the next tick count reaches the factor
  assign expire = tick && (14'(tick_r + 14'h0001) == factor(sel_r));

  // prescaler: cleared on refresh and while firing, frozen when stopped
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_r <= 9'h000;
    end else if (state_r == wdg_pkg::st_fire) begin
      presc_r <= 9'h000;
    end else if (refresh_evt) begin
      presc_r <= 9'h000;
    end else if (tick) begin
      presc_r <= 9'h000;
    end else if (state_r == wdg_pkg::st_run) begin
      presc_r <= 9'(presc_r + 9'h001);
    end
  end

  // tick counter: counts ticks since the last refresh or timeout
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_r <= 14'h0000;
    end else if (state_r == wdg_pkg::st_fire) begin
      tick_r <= 14'h0000;
    end else if (refresh_evt) begin
      tick_r <= 14'h0000;
    end else if (expire) begin
      tick_r <= 14'h0000;
    end else if (tick) begin
      tick_r <= 14'(tick_r + 14'h0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  // refresh wins over timeout and sleep in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= wdg_pkg::st_run;
    end else begin
      unique case (state_r)
        wdg_pkg::st_run: begin
          if (refresh_evt) begin
            state_r <= wdg_pkg::st_run;
          end else if (expire) begin
            state_r <= wdg_pkg::st_fire;
          end else if (sleep_evt && sw_mode) begin
            state_r <= wdg_pkg::st_stop;
          end                                // sleep ignored
        end
        wdg_pkg::st_stop: begin
          // hardware mode cannot stay stopped
          if (refresh_evt || !sw_mode) begin
            state_r <= wdg_pkg::st_run;
          end
        end
        wdg_pkg::st_fire: begin
          // back to counting once the pulse is out
          if (fire_r == 3'(wdg_pkg::RST_LEN - 1)) begin
            state_r <= wdg_pkg::st_run;
          end
        end
        // the unused code falls back to counting
        default: begin
          state_r <= wdg_pkg::st_run;
        end
      endcase
    end
  end

  // reset pulse length counter
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fire_r <= 3'h0;
    end else if (state_r == wdg_pkg::st_fire) begin
      fire_r <= 3'(fire_r + 3'h1);
    end else begin
      fire_r <= 3'h0;
    end
  end

  // core reset output, low one cycle after the timeout
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_n_r <= 1'b1;
    end else if (state_r == wdg_pkg::st_run) begin
      rst_n_r <= ~(expire & ~refresh_evt);
    end else if (state_r == wdg_pkg::st_fire) begin
      rst_n_r <= (fire_r == 3'(wdg_pkg::RST_LEN - 1));
    end else begin
      rst_n_r <= 1'b1;
    end
  end

  assign core_rst_n_o = rst_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // marks the first cycle after reset release
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // reset pulse: four low cycles then high
  sequence s_rst_pulse;
    !core_rst_n_o [*4] ##1 core_rst_n_o;
  endsequence

  // sleep taken in software mode
  sequence s_sw_sleep;
    state_r == wdg_pkg::st_run && sleep_evt && !refresh_evt && !expire
      && opt_r == 8'hAA;
  endsequence

  property p_timeout;
    state_r == wdg_pkg::st_run && expire && !refresh_evt |=> s_rst_pulse;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not give a four cycle reset");

  property p_refresh;
    refresh_evt && state_r != wdg_pkg::st_fire
      |=> presc_r == 9'h000 && tick_r == 14'h0000
          && state_r == wdg_pkg::st_run;
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh did not restart the count");

  property p_sw_sleep;
    s_sw_sleep |=> state_r == wdg_pkg::st_stop
      ##1 ($stable(presc_r) || $past(refresh_evt));
  endproperty
  a_sw_sleep: assert property (p_sw_sleep)
    else $error("sleep in software mode did not stop");

  property p_hw_sleep;
    state_r == wdg_pkg::st_run && opt_r != 8'hAA |=> state_r != wdg_pkg::st_stop;
  endproperty
  a_hw_sleep: assert property (p_hw_sleep)
    else $error("hardware mode watchdog stopped");

  property p_after_reset;
    first_r |-> state_r == wdg_pkg::st_run && !sw_mode && sel_r == 4'h1
                && core_rst_n_o;
  endproperty
  a_after_reset: assert property (p_after_reset)
    else $error("wrong state after reset");

  property p_presc;
    state_r == wdg_pkg::st_run && !refresh_evt && !tick
      |=> presc_r == 9'($past(presc_r) + 9'h001);
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler did not advance");

  property p_factor;
    expire |-> 14'(tick_r + 14'h0001)
      == ((sel_r == 4'h0) ? 14'h0001 : 14'(625 * int'(sel_r)));
  endproperty
  a_factor: assert property (p_factor)
    else $error("timeout at wrong tick count");

  property p_ctrl_read;
    read_i && !waitrequest_o && address_i == 8'h1C
      |-> readdata_o[31:4] == 28'h000_0000 && readdata_o[3:0] == sel_r;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control register read wrong");

endmodule : wdg_timer

// ==== wdg_timer_tb_top.sv ====
// self-checking testbench for the watchdog timer
// assumes wdg_pkg and wdg_timer are compiled first; prescaler shortened to 4
`timescale 1ns/10ps

module wdg_timer_tb_top;
  ////////////////////////////////////////////////////////////////////////////
  // settings and stimulus signals
  localparam int unsigned PDIV = 4;                                  // shortened prescaler
  localparam logic [7:0]  A_OPT = {wdg_pkg::IDX_OPTION[5:0], 2'b00}; // option byte address
  localparam logic [7:0]  A_CTL = {wdg_pkg::IDX_CTRL[5:0], 2'b00};   // control address
  localparam logic [7:0]  A_STA = {wdg_pkg::IDX_STATUS[5:0], 2'b00}; // status address
  localparam logic [7:0]  A_CMD = {wdg_pkg::IDX_CMD[5:0], 2'b00};    // command address
  logic        core_clk_i = 1'b0;         // 40 mhz clock
  logic        rst_i = 1'b1;              // async reset
  logic [7:0]  address_i = 8'h00;         // bus address
  logic        read_i = 1'b0;             // bus read
  logic        write_i = 1'b0;            // bus write
  logic [3:0]  byteenable_i = 4'hf;       // byte lanes
  logic [31:0] writedata_i = 32'h0000_0000; // write data
  logic        refresh_instr_i = 1'b0;    // refresh pulse
  logic        sleep_instr_i = 1'b0;      // sleep pulse
  logic [31:0] readdata_o;                // read data
  logic        waitrequest_o;             // bus stall
  logic        core_rst_n_o;              // core reset, low active
  logic [31:0] q;                         // last read value
  int          num_errors = 0;            // mismatches
  int          n_tests = 0;               // comparisons

  // clock: 25 ns period
  always #12.5 core_clk_i = ~core_clk_i;

  wdg_timer #(.PRESC_DIV(PDIV)) dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .refresh_instr_i(refresh_instr_i), .sleep_instr_i(sleep_instr_i),
    .core_rst_n_o(core_rst_n_o));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // one comparison; a failure prints and counts
  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  // one avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rdat);
    int k;
    k = 0;
    @(posedge core_clk_i);
    address_i    <= a;
    writedata_i  <= d;
    byteenable_i <= be;
    write_i      <= wr;
    read_i       <= ~wr;
    // waitrequest and read data are sampled at the rising edge itself, before it updates them
    do begin
      @(posedge core_clk_i);
      k++;
    end while (waitrequest_o !== 1'b0 && k < 20);
    chk(k < 20, "bus answer missing");
    rdat = readdata_o;
    // released only after the answer edge
    write_i <= 1'b0;
    read_i  <= 1'b0;
  endtask : bus

  // register write with all lanes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, 4'hf, dummy);
  endtask : wr

  // read and compare the low byte, upper bits must read 0
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk(q === {24'h00_0000, exp}, msg);
  endtask : rd_chk

  // reset held for 5 cycles
  task automatic do_reset();
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  // refresh pulse sent only while no reset pulse is driven; retried if swallowed
  task automatic do_refresh();
    for (int i = 0; i < 3; i++) begin
      while (core_rst_n_o !== 1'b1) @(negedge core_clk_i);
      @(posedge core_clk_i);
      refresh_instr_i <= 1'b1;
      @(posedge core_clk_i);
      refresh_instr_i <= 1'b0;
      @(negedge core_clk_i);
      if (core_rst_n_o === 1'b1) break;
    end
  endtask : do_refresh

  // core reset must fall within lo..hi cycles and stay low four cycles
  task automatic expect_fire(input int lo, input int hi);
    int n;
    int m;
    n = 0;
    m = 1;
    while (n < hi && core_rst_n_o !== 1'b0) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(core_rst_n_o === 1'b0 && n >= lo, "timeout reset at wrong time");
    @(negedge core_clk_i);
    while (core_rst_n_o === 1'b0 && m < 10) begin
      m++;
      @(negedge core_clk_i);
    end
    chk(m == wdg_pkg::RST_LEN, "core reset pulse length wrong");
  endtask : expect_fire

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  // reset state, unmapped address, refused write
  task automatic t_reset_state();
    rd_chk(A_OPT, 8'h00, "option reset value");
    rd_chk(A_CTL, 8'h01, "control reset value");
    rd_chk(A_STA, 8'h01, "status not running in hardware mode");
    rd_chk(8'h3c, 8'h00, "unmapped read not zero");
    bus(1'b1, A_CTL, 32'h0000_0005, 4'he, q);
    rd_chk(A_CTL, 8'h01, "write without lane 0 took effect");
  endtask : t_reset_state

  // all sixteen selectors stored, upper nibble dropped
  task automatic t_selectors();
    for (int i = 0; i < 16; i++) begin
      wr(A_CTL, {24'h00_0000, 4'hf, 4'(i)});
      rd_chk(A_CTL, {4'h0, 4'(i)}, "selector readback");
    end
  endtask : t_selectors

  // timeout length for a selector: factor times prescaler cycles
  task automatic t_timeout(input logic [3:0] sel, input int factor);
    wr(A_CTL, {28'h000_0000, sel});
    do_refresh();
    expect_fire(factor * PDIV - 2, factor * PDIV + 3);
  endtask : t_timeout

  // refresh through the command register restarts a running count
  task automatic t_restart();
    wr(A_CTL, 32'h0000_0001);
    do_refresh();
    repeat (2000) @(negedge core_clk_i);
    chk(core_rst_n_o === 1'b1, "reset before timeout");
    wr(A_CMD, 32'h0000_0001);
    expect_fire(625 * PDIV - 2, 625 * PDIV + 3);
  endtask : t_restart

  // sleep honoured only with the one software code
  task automatic t_mode(input logic [7:0] code);
    bit sw;
    sw = (code == 8'haa);
    wr(A_OPT, {24'h00_0000, code});
    wr(A_CTL, 32'h0000_0000);
    do_refresh();
    @(posedge core_clk_i);
    sleep_instr_i <= 1'b1;
    @(posedge core_clk_i);
    sleep_instr_i <= 1'b0;
    if (sw) begin
      repeat (200) @(negedge core_clk_i);
      chk(core_rst_n_o === 1'b1, "sleep did not stop software watchdog");
      rd_chk(A_STA, 8'h0a, "status not stopped in software mode");
      do_refresh();
      expect_fire(1, 8);
    end else begin
      expect_fire(1, 8);
    end
    wr(A_CTL, 32'h0000_0001);
  endtask : t_mode

  ////////////////////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or the watchdog
  task automatic end_of_test();
    $display("errors %0d, comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // hang guard: the tests need about 45000 cycles
  initial begin
    #1500000;
    num_errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    do_reset();
    t_reset_state();
    t_selectors();
    t_timeout(4'h0, 1);
    t_timeout(4'h1, 625);
    t_timeout(4'hf, 9375);
    t_restart();
    t_mode(8'h55);
    t_mode(8'hab);
    t_mode(8'haa);
    do_reset();
    t_reset_state();
    end_of_test();
  end
endmodule : wdg_timer_tb_top
